// ===== verilog/skip_branch_and_irq_context.sv
// Functional notes
// - Interrupt entry pushes only the return address
// - Top 16 bytes of each bank shared
// - Decrement-skip writes file minus one, no flags
// - Destination bit: 0 accumulator, 1 file register
// - Decrement result zero turns next into no-op
// - Increment-skip writes file plus one, no flags
// - Increment result zero turns next into no-op
// - File operand 0..127, one destination bit
// - Jump loads 11-bit literal into low PC
// - Jump takes PC upper bits from latch bits 4:3
`timescale 1ns/1ns
`default_nettype none

module skip_branch_and_irq_context (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [13:0] instr_in,
  input  wire logic [7:0]  file_rdata,
  input  wire logic [1:0]  ram_bank,
  input  wire logic [4:0]  program_counter_latch_high,
  input  wire logic        irq_request,
  output logic      [12:0] prog_addr,
  output logic      [8:0]  file_raddr,
  output logic             file_we,
  output logic      [8:0]  file_waddr,
  output logic      [7:0]  file_wdata,
  output logic             acc_we,
  output logic      [7:0]  acc_wdata,
  output logic             stack_push,
  output logic      [12:0] stack_push_data,
  output logic             irq_ack
);

  // Checks run on the core clock, off during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Two-stage pipeline: fetch, then execute
  // Fetch cycle shows prog_addr and maps the operand
  // Execute cycle sees file_rdata of that operand
  // Results leave one edge after execute
  // A cleared ir_valid turns the slot into a no-op
  // Skips and jumps clear it for the word behind them
  // Interrupt entry clears it for the word fetched at the return address
  // Flags are not kept here, none are ever written
  // Whole state of the core slice
  typedef struct packed {
    logic [12:0] pc;         // Address being fetched
    logic [13:0] ir;         // Instruction in execute
    logic        ir_valid;   // Low means execute a no-op
    logic [8:0]  raddr;      // Mapped file address of fetched word
    logic        file_we;    // File register write strobe
    logic [8:0]  file_waddr; // File register write address
    logic [7:0]  file_wdata; // File register write data
    logic        acc_we;     // Accumulator write strobe
    logic [7:0]  acc_wdata;  // Accumulator write data
    logic        push;       // Stack push strobe
    logic [12:0] push_data;  // Return address pushed
    logic        irq_ack;    // Interrupt taken pulse
  } core_state_t;

  core_state_t state;       // Registered state
  core_state_t next_state;  // Next state

  // Decode helpers
  logic [5:0]  opcode;      // Upper opcode field
  logic        dest;        // Destination select bit
  logic        is_dec;      // Decrement-skip executing
  logic        is_inc;      // Increment-skip executing
  logic        is_jump;     // Jump executing
  logic [7:0]  result;      // Incremented or decremented value
  logic        skip;        // Skip condition met
  logic        branch;      // Fetched word must be flushed
  logic        irq_take;    // Interrupt accepted this cycle
  logic [12:0] jump_target; // Target built from literal and latch

  // Address mapper link
  ram_map_if map_link ();

  // Bank and offset of the word just fetched
  assign map_link.bank   = ram_bank;
  assign map_link.offset = instr_in[skip_core_pkg::FILE_HI:0];

  // Mapper folds shared area of the banks
  ram_bank_mapper u_mapper (
    .map (map_link.mapper)
  );

  // Opcode sits in the top bits of the word
  // Jump is told by its three top bits alone
  // Instruction decode of the executing word
  always_comb begin
    opcode  = state.ir[skip_core_pkg::OP_HI:skip_core_pkg::OP_LO];
    dest    = state.ir[skip_core_pkg::DEST_BIT];
    is_dec  = state.ir_valid && (opcode == skip_core_pkg::OP_DEC_SKIP);
    is_inc  = state.ir_valid && (opcode == skip_core_pkg::OP_INC_SKIP);
    is_jump = state.ir_valid &&
              (state.ir[skip_core_pkg::OP_HI:skip_core_pkg::JMP_OP_LO]
               == skip_core_pkg::OP_JUMP);
  end

  // Result is formed for every word, used only by skips
  // Zero test decides the skip, nothing else
  // Arithmetic and control flow decisions
  always_comb begin
    // Flags are never touched by these operations
    if (is_dec) begin
      result = file_rdata - skip_core_pkg::DATA_ONE;
    end else begin
      result = file_rdata + skip_core_pkg::DATA_ONE;
    end
    // Zero result drops the next instruction
    skip   = (is_dec || is_inc) && (result == skip_core_pkg::DATA_ZERO);
    branch = is_jump || skip;
    // Interrupt waits until no flush is pending
    irq_take = irq_request && state.ir_valid && !branch;
    // Literal into low bits, latch bits into high bits
    jump_target = {program_counter_latch_high[skip_core_pkg::LATCH_HI:skip_core_pkg::LATCH_LO],
                   state.ir[skip_core_pkg::LIT_HI:0]};
  end

  // Only this process builds the next state copy
  // Priority: jump, then interrupt, then plain step
  // Interrupt cannot fire in a slot that branches
  // Next state build
  always_comb begin
    next_state = state;
    // Program counter sequencing
    if (is_jump) begin
      next_state.pc = jump_target;
    end else if (irq_take) begin
      next_state.pc = skip_core_pkg::IRQ_VECTOR;
    end else begin
      next_state.pc = state.pc + skip_core_pkg::PC_STEP;
    end
    // Fetched word moves to execute, or becomes a no-op
    next_state.ir        = instr_in;
    next_state.ir_valid  = !(branch || irq_take);
    next_state.raddr     = map_link.phys;
    // Result routing by destination bit, full 7-bit file operand
    next_state.acc_we     = (is_dec || is_inc) && (dest == skip_core_pkg::DEST_ACC);
    next_state.file_we    = (is_dec || is_inc) && (dest == skip_core_pkg::DEST_FILE);
    next_state.acc_wdata  = result;
    next_state.file_wdata = result;
    // Write goes to the operand address of the executing word
    next_state.file_waddr = state.raddr;
    // Interrupt entry saves only the return address
    next_state.push      = irq_take;
    next_state.push_data = state.pc;
    next_state.irq_ack   = irq_take;
  end

  // Reset clears every strobe and makes the slot a no-op
  // Fetch restarts at the reset address
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
      state.pc <= skip_core_pkg::RESET_PC;
    end else begin
      state <= next_state;
    end
  end

  // No logic between the register and the pins
  // Outputs straight from the state register
  assign prog_addr       = state.pc;
  assign file_raddr      = state.raddr;
  assign file_we         = state.file_we;
  assign file_waddr      = state.file_waddr;
  assign file_wdata      = state.file_wdata;
  assign acc_we          = state.acc_we;
  assign acc_wdata       = state.acc_wdata;
  assign stack_push      = state.push;
  assign stack_push_data = state.push_data;
  assign irq_ack         = state.irq_ack;

  // Interrupt push carries fetch address; writes only from the executing word
  a_irq_push_only: assert property (
    irq_take |=> stack_push && irq_ack && (stack_push_data == $past(state.pc))
                 && ((acc_we || file_we) == $past(is_dec || is_inc))
                 && (prog_addr == skip_core_pkg::IRQ_VECTOR))
    else $error("interrupt entry did more than push return address");

  // Shared area ignores bank bits
  a_common_area_map: assert property (
    (map_link.offset >= skip_core_pkg::COMMON_BASE) |->
      (map_link.phys == {skip_core_pkg::COMMON_BANK, map_link.offset}))
    else $error("top bank location not mapped to shared area");

  // Decrement result reaches its destination
  a_dec_result: assert property (
    is_dec |=> (acc_we || file_we) &&
      (acc_wdata == $past(file_rdata) - skip_core_pkg::DATA_ONE))
    else $error("decrement-skip result wrong");

  // Destination bit steers the write
  a_dest_select: assert property (
    (is_dec || is_inc) |=> (acc_we == !$past(dest)) && (file_we == $past(dest))
                          && (file_waddr == $past(file_raddr)))
    else $error("destination select wrong");

  // Zero decrement flushes next, nonzero keeps it
  a_dec_skip: assert property (
    (is_dec && !irq_request) |=>
      (state.ir_valid == ($past(file_rdata) != skip_core_pkg::DATA_ONE)))
    else $error("decrement skip decision wrong");

  // Increment result reaches its destination
  a_inc_result: assert property (
    is_inc |=> (acc_we || file_we) &&
      (file_wdata == $past(file_rdata) + skip_core_pkg::DATA_ONE))
    else $error("increment-skip result wrong");

  // Increment wrapping to zero flushes next
  a_inc_skip: assert property (
    (is_inc && (file_rdata == 8'hFF)) |=> !state.ir_valid ##1 state.ir_valid || !is_jump)
    else $error("increment skip did not flush");

  // Jump target low bits and one-slot flush
  a_jump_target: assert property (
    is_jump |=> (prog_addr[10:0] == $past(state.ir[10:0])) && !state.ir_valid)
    else $error("jump low bits wrong");

  a_jump_upper: assert property (
    is_jump |=> (prog_addr[12:11] == $past(program_counter_latch_high[4:3])))
    else $error("jump upper bits not from latch");

  // Skip or jump flush leaves no write behind the flushed slot
  a_flush_noop: assert property (
    branch |=> !state.ir_valid ##1 (!acc_we && !file_we && !stack_push))
    else $error("flushed instruction still acted");

  // Further checks on sequencing and routing

  // Banked offsets keep their bank bits
  a_banked_map: assert property (
    (map_link.offset < skip_core_pkg::COMMON_BASE) |->
      (map_link.phys == {map_link.bank, map_link.offset}))
    else $error("banked location mapped to wrong bank");

  // Offset bits pass through unchanged
  a_offset_pass: assert property (
    map_link.phys[skip_core_pkg::FILE_HI:0] == map_link.offset)
    else $error("file operand offset altered");

  // Nonzero increment keeps the next word
  a_inc_keep: assert property (
    (is_inc && !irq_request) |=> (state.ir_valid == ($past(file_rdata) != 8'hFF)))
    else $error("increment skip decision wrong");

  // Decrement into the file register
  a_dec_file_value: assert property (
    (is_dec && (dest == skip_core_pkg::DEST_FILE)) |=> file_we &&
      (file_wdata == $past(file_rdata) - skip_core_pkg::DATA_ONE))
    else $error("decrement-skip file write wrong");

  // Increment into the accumulator
  a_inc_acc_value: assert property (
    (is_inc && (dest == skip_core_pkg::DEST_ACC)) |=> acc_we &&
      (acc_wdata == $past(file_rdata) + skip_core_pkg::DATA_ONE))
    else $error("increment-skip accumulator write wrong");

  // Other words write nothing
  a_other_no_write: assert property (
    !(is_dec || is_inc) |=> !acc_we && !file_we)
    else $error("write without a skip instruction");

  // Jump writes no data and pushes nothing
  a_jump_no_data: assert property (
    is_jump |=> !acc_we && !file_we && !stack_push)
    else $error("jump touched data or stack");

  // Jump target runs after one no-op slot
  a_jump_two_cycle: assert property (
    is_jump |=> !state.ir_valid ##1
      (state.ir_valid && (prog_addr == $past(prog_addr) + skip_core_pkg::PC_STEP)))
    else $error("jump did not take two cycles");

  // Plain words step the fetch address by one
  a_pc_sequence: assert property (
    (!is_jump && !irq_take) |=> (prog_addr == $past(prog_addr) + skip_core_pkg::PC_STEP))
    else $error("fetch address did not step");

  // Taken branch holds off the interrupt
  a_branch_no_irq: assert property (
    branch |=> !stack_push && !irq_ack)
    else $error("interrupt taken beside a flush");

  // No-op slot never takes the interrupt
  a_irq_wait: assert property (
    !state.ir_valid |=> !stack_push && !irq_ack)
    else $error("interrupt taken in a no-op slot");

  // Push is a single-cycle pulse
  a_push_pulse: assert property (
    stack_push |=> !stack_push)
    else $error("stack push held too long");

  // Acknowledge comes with the push to the vector
  a_ack_with_push: assert property (
    irq_ack |-> stack_push && (prog_addr == skip_core_pkg::IRQ_VECTOR))
    else $error("acknowledge without push to vector");

  // A no-op slot leaves no write behind
  a_idle_slot: assert property (
    !state.ir_valid |=> !acc_we && !file_we)
    else $error("no-op slot wrote data");

endmodule

`default_nettype wire

// ===== verilog/skip_core_pkg.sv
package skip_core_pkg;

  // Widths of the core datapath
  localparam int PC_W        = 13;
  localparam int IR_W        = 14;
  localparam int DATA_W      = 8;
  localparam int OFFSET_W    = 7;
  localparam int BANK_W      = 2;
  localparam int PHYS_W      = 9;
  localparam int LATCH_W     = 5;

  // Instruction field positions
  localparam int OP_HI       = 13;
  localparam int OP_LO       = 8;
  localparam int DEST_BIT    = 7;
  localparam int FILE_HI     = 6;
  localparam int JMP_OP_LO   = 11;
  localparam int LIT_HI      = 10;
  localparam int LATCH_HI    = 4;
  localparam int LATCH_LO    = 3;

  // Opcode encodings of the handled instructions
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;
  localparam logic [2:0] OP_JUMP     = 3'h5;

  // Destination select values
  localparam logic DEST_ACC  = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // Program counter values
  localparam logic [12:0] RESET_PC   = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_STEP    = 13'h0001;

  // Data step for increment and decrement
  localparam logic [7:0] DATA_ONE  = 8'h01;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // Shared area at the top of every bank
  localparam int         COMMON_SIZE = 16;
  localparam logic [6:0] COMMON_BASE = 7'h70;
  localparam logic [1:0] COMMON_BANK = 2'h0;

endpackage

// ===== verilog/ram_map_if.sv
`timescale 1ns/1ns
`default_nettype none

// Bank plus offset in, physical data-RAM address out
interface ram_map_if;
  logic [1:0] bank;    // Bank select bits
  logic [6:0] offset;  // Offset within bank
  logic [8:0] phys;    // Physical RAM address

  modport requester (output bank, output offset, input phys);
  modport mapper    (input bank, input offset, output phys);
endinterface

`default_nettype wire

// ===== verilog/ram_bank_mapper.sv
`timescale 1ns/1ns
`default_nettype none

// Folds the top locations of each bank onto one shared area
module ram_bank_mapper (
  ram_map_if.mapper map
);

  // Top offsets ignore the bank bits, all others are banked
  always_comb begin
    if (map.offset >= skip_core_pkg::COMMON_BASE) begin
      map.phys = {skip_core_pkg::COMMON_BANK, map.offset};
    end else begin
      map.phys = {map.bank, map.offset};
    end
  end

endmodule

`default_nettype wire

// ===== dv/skip_branch_and_irq_context_test.sv
`timescale 1ns/1ns
`default_nettype none

module skip_branch_and_irq_context_test;
  logic        sys_clk;                     // Core clock
  logic        reset;                       // Synchronous reset
  logic [13:0] instr_in;                    // Fetched word
  logic [7:0]  file_rdata;                  // Operand data
  logic [1:0]  ram_bank;                    // Bank select
  logic [4:0]  program_counter_latch_high;  // Upper PC latch
  logic        irq_request;                 // Interrupt request
  logic [12:0] prog_addr;                   // Fetch address
  logic [8:0]  file_raddr;                  // Operand read address
  logic        file_we;                     // File write strobe
  logic [8:0]  file_waddr;                  // File write address
  logic [7:0]  file_wdata;                  // File write data
  logic        acc_we;                      // Accumulator strobe
  logic [7:0]  acc_wdata;                   // Accumulator data
  logic        stack_push;                  // Push strobe
  logic [12:0] stack_push_data;             // Pushed address
  logic        irq_ack;                     // Interrupt taken
  logic [13:0] rom [0:8191];                // Program memory model
  logic [7:0]  ram [0:511];                 // Data memory model
  logic [7:0]  accq [$];                    // Accumulator writes seen
  logic [16:0] fq [$];                      // File writes seen, address and data
  logic [12:0] pushq [$];                   // Pushes seen
  int          n_ack;                       // Interrupt acks seen
  int          n_fail;                      // Mismatch count
  int          n_tests;                     // Comparison count

  skip_branch_and_irq_context dut (
    .sys_clk(sys_clk), .reset(reset), .instr_in(instr_in), .file_rdata(file_rdata),
    .ram_bank(ram_bank), .program_counter_latch_high(program_counter_latch_high),
    .irq_request(irq_request), .prog_addr(prog_addr), .file_raddr(file_raddr),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .irq_ack(irq_ack)
  );

  // Free running clock, 50 ns period
  always #25 sys_clk = ~sys_clk;

  // Skip-type word from opcode, destination and file operand
  function automatic logic [13:0] fsk(logic [5:0] op, logic d, logic [6:0] f);
    return {op, d, f};
  endfunction

  // Compare one value and count it
  task automatic chk(logic [19:0] got, logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One cycle: log strobes, then serve both memories off the edge
  task automatic step();
    @(posedge sys_clk);
    #1;
    if (reset === 1'b0) begin
      if (acc_we === 1'b1) accq.push_back(acc_wdata);
      if (file_we === 1'b1) fq.push_back({file_waddr, file_wdata});
      if (stack_push === 1'b1) pushq.push_back(stack_push_data);
      if (irq_ack === 1'b1) begin
        n_ack++;
        irq_request = 1'b0;
      end
    end
    instr_in   = rom[prog_addr];
    file_rdata = ram[file_raddr];
  endtask

  // Blank program, clear logs
  task automatic clear_all();
    for (int i = 0; i < 8192; i++) rom[i] = 14'h0000;
    accq.delete();
    fq.delete();
    pushq.delete();
    n_ack = 0;
  endtask

  // Reset for a few cycles, then run the program
  task automatic run(int n);
    reset = 1'b1;
    repeat (2) step();
    reset = 1'b0;
    repeat (n) step();
  endtask

  // Decrement nonzero to accumulator, next word runs; shared top, banked low
  task automatic t_dec_plain();
    clear_all();
    ram_bank = 2'h3;
    rom[0] = fsk(skip_core_pkg::OP_DEC_SKIP, 1'b0, 7'h7F);
    rom[1] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b0, 7'h70);
    rom[2] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b1, 7'h05);
    ram[9'h07F] = 8'h05;
    ram[9'h070] = 8'h10;
    ram[9'h185] = 8'h20;
    run(8);
    chk(16'(accq.size()), 16'h0002);
    chk(16'(accq[0]), 16'h0004);
    chk(16'(accq[1]), 16'h0011);
    chk(16'(fq.size()), 16'h0001);
    chk(20'(fq[0]), 20'h18521);
    chk(16'(file_raddr), 16'h0180);
  endtask

  // Decrement to zero into file register, following word flushed
  task automatic t_dec_zero();
    clear_all();
    ram_bank = 2'h3;
    rom[0] = fsk(skip_core_pkg::OP_DEC_SKIP, 1'b1, 7'h71);
    rom[1] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b1, 7'h70);
    rom[2] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b0, 7'h70);
    ram[9'h071] = 8'h01;
    ram[9'h070] = 8'h10;
    run(8);
    chk(16'(fq.size()), 16'h0001);
    chk(16'(fq[0]), 16'h7100);
    chk(16'(accq.size()), 16'h0001);
    chk(16'(accq[0]), 16'h0011);
  endtask

  // Increment wraps to zero, next word skipped, then file write
  task automatic t_inc_zero();
    clear_all();
    ram_bank = 2'h1;
    rom[0] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b0, 7'h7E);
    rom[1] = fsk(skip_core_pkg::OP_DEC_SKIP, 1'b0, 7'h70);
    rom[2] = fsk(skip_core_pkg::OP_DEC_SKIP, 1'b1, 7'h72);
    ram[9'h07E] = 8'hFF;
    ram[9'h070] = 8'h10;
    ram[9'h072] = 8'h03;
    run(8);
    chk(16'(accq.size()), 16'h0001);
    chk(16'(accq[0]), 16'h0000);
    chk(16'(fq[0]), 16'h7202);
  endtask

  // Jump with upper bits from latch, flushed slot writes nothing
  task automatic t_jump();
    clear_all();
    program_counter_latch_high = 5'h1F;
    rom[0] = {skip_core_pkg::OP_JUMP, 11'h7F8};
    rom[1] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b1, 7'h70);
    rom[13'h1FF8] = fsk(skip_core_pkg::OP_DEC_SKIP, 1'b0, 7'h70);
    ram[9'h070] = 8'h10;
    run(7);
    chk(16'(fq.size()), 16'h0000);
    chk(16'(accq.size()), 16'h0001);
    chk(16'(accq[0]), 16'h000F);
    chk(16'(prog_addr), 16'h1FFD);
  endtask

  // Interrupt pushes the return address only, then runs the vector
  task automatic t_irq();
    clear_all();
    irq_request = 1'b1;
    rom[0] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b0, 7'h70);
    rom[1] = fsk(skip_core_pkg::OP_INC_SKIP, 1'b1, 7'h70);
    rom[4] = fsk(skip_core_pkg::OP_DEC_SKIP, 1'b0, 7'h70);
    ram[9'h070] = 8'h10;
    run(8);
    chk(16'(pushq.size()), 16'h0001);
    chk(16'(pushq[0]), 16'h0001);
    chk(16'(n_ack), 16'h0001);
    chk(16'(accq.size()), 16'h0002);
    chk(16'(accq[1]), 16'h000F);
    chk(16'(fq.size()), 16'h0000);
  endtask

  // Print counts and verdict, end the run
  task automatic test_done();
    $display("Counts: tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    instr_in = 14'h0000;
    file_rdata = 8'h00;
    ram_bank = 2'h0;
    program_counter_latch_high = 5'h00;
    irq_request = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (16) step();
    t_dec_plain();
    t_dec_zero();
    t_inc_zero();
    t_jump();
    t_irq();
    test_done();
  end

  // Watchdog, well beyond the 65 cycles the tests need
  initial begin
    #(2000 * 50);
    n_fail++;
    test_done();
  end
endmodule

`default_nettype wire
